/* design/spg_core.sv */
// How it works
// - Status request answers seven bytes: mark, 04H, status, three zeros, checksum.
// - Checksum is two's complement of status plus reserved bytes.
// - Status bit 1 shows read protection on.
// - Status bit 0 is one when the top 32 bytes are not all FFH.
// - Status bits 7 to 2 are always zero.
// - Flash write and RAM loader are refused while read protection is on.
// - Checksum, status, ID always allowed; otherwise non-blank unprotected needs a password.
// - A refused command is echoed, then the device halts.
// - Erase area byte: upper nibble first block, lower nibble last block.
// - Start nibble k gives k*1000H; end nibble gives k*1000H+0FFFH.
// - Start not above end erases the 4 kbyte sectors start through end; under read protection no sector erase starts.
// - Start above end erases the whole array and clears protection.
// - Sector erase over blocks without cells halts the device.
// - In serial mode all port inputs except both UART pins are forced off.
// - Writing one to the port input enable makes port inputs valid again.
// - Port input enable answers only in serial mode; else writes ignored.
// - Password mismatch or format error halts silently until reset.
`timescale 1ns/100ps
`default_nettype none
module spg_core #(
  parameter int PORT_BITS = 24
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_nrst,
  input  wire logic                 i_serial_mode,
  input  wire logic [7:0]           i_rx_data,
  input  wire logic                 i_rx_valid,
  output logic [7:0]                o_tx_data,
  output logic                      o_tx_valid,
  input  wire logic                 i_tx_ready,
  input  wire logic                 i_read_protect_flag,
  input  wire logic                 i_top_not_blank,
  input  wire logic                 i_password_error,
  input  wire logic                 i_service_done,
  output logic                      o_service_start,
  output logic [7:0]                o_service_cmd,
  output logic                      o_service_needs_password,
  output logic                      o_erase_start,
  output logic                      o_erase_chip,
  output logic [15:0]               o_erase_start_addr,
  output logic [15:0]               o_erase_end_addr,
  input  wire logic                 i_erase_done,
  output logic                      o_clear_protect,
  input  wire logic [3:0]           i_first_flash_block,
  input  wire logic [3:0]           i_last_flash_block,
  input  wire logic                 i_port_en_wr,
  input  wire logic                 i_port_en_wdata,
  output logic                      o_port_en_rdata,
  input  wire logic [PORT_BITS-1:0] i_port_pins,
  output logic [PORT_BITS-1:0]      o_port_inputs,
  input  wire logic                 i_uart_port_pin_a,
  input  wire logic                 i_uart_port_pin_b,
  output logic                      o_uart_port_pin_a,
  output logic                      o_uart_port_pin_b,
  output logic                      o_halted
);
  import spg_pkg::*;

  initial begin
    if (PORT_BITS < 1 || PORT_BITS > 64) begin
      $error("PORT_BITS out of range");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  spg_state_type      state_q, state_d;
  logic [7:0]         cmd_q, cmd_d;
  logic [1:0]         flags_q, flags_d;
  logic [2:0]         idx_q, idx_d;
  logic [7:0]         tx_q, tx_d;
  logic               txv_q, txv_d;
  logic               echo_halt_q, echo_halt_d;
  logic               pass_q, pass_d;
  logic               chip_q, chip_d;
  logic [15:0]        sa_q, sa_d;
  logic [15:0]        ea_q, ea_d;
  logic               erase_go_q, erase_go_d;
  logic               svc_go_q, svc_go_d;
  logic               clr_q, clr_d;
  logic               port_en_q, port_en_d;
  logic [PORT_BITS-1:0] pin_m_q, pin_s_q;
  logic [PORT_BITS-1:0] port_q, port_d;
  logic [1:0]         uart_m_q, uart_s_q;

  spg_perm_type       perm;
  logic               known;
  logic               area_chip;
  logic               area_no_cells;
  logic [15:0]        area_start;
  logic [15:0]        area_end;
  logic [7:0]         status_byte;

  spg_perm u_perm (
    .i_cmd               (i_rx_data),
    .i_read_protect_flag (i_read_protect_flag),
    .i_not_blank         (i_top_not_blank),
    .o_perm              (perm),
    .o_known             (known)
  );

  spg_area u_area (
    .i_area              (i_rx_data),
    .i_first_flash_block (i_first_flash_block),
    .i_last_flash_block  (i_last_flash_block),
    .o_chip              (area_chip),
    .o_start_addr        (area_start),
    .o_end_addr          (area_end),
    .o_no_cells          (area_no_cells)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    status_byte = 8'h00;
    status_byte[RPROT_BIT] = flags_q[1];
    status_byte[BLANK_BIT] = flags_q[0];
  end

  always_comb begin
    state_d     = state_q;
    cmd_d       = cmd_q;
    flags_d     = flags_q;
    idx_d       = idx_q;
    tx_d        = tx_q;
    txv_d       = txv_q;
    echo_halt_d = echo_halt_q;
    pass_d      = pass_q;
    chip_d      = chip_q;
    sa_d        = sa_q;
    ea_d        = ea_q;
    erase_go_d  = 1'b0;
    svc_go_d    = 1'b0;
    clr_d       = 1'b0;
    if (txv_q && i_tx_ready) begin
      txv_d = 1'b0;
    end
    case (state_q)
      SPG_IDLE: begin
        if (i_rx_valid && i_serial_mode) begin
          cmd_d   = i_rx_data;
          flags_d = {i_read_protect_flag, i_top_not_blank};
          pass_d  = (perm == SPG_PASS);
          echo_halt_d = (perm == SPG_DENY) || !known;
          tx_d    = i_rx_data;
          txv_d   = 1'b1;
          state_d = SPG_ECHO;
        end
      end
      SPG_ECHO: begin
        if (!txv_q) begin
          if (echo_halt_q) begin
            state_d = SPG_HALT;
          end else if (cmd_q == CMD_STATUS_OUT) begin
            idx_d   = 3'd0;
            tx_d    = START_MARK;
            txv_d   = 1'b1;
            state_d = SPG_STAT;
          end else if (cmd_q == CMD_ERASE) begin
            state_d = SPG_ARG;
          end else begin
            svc_go_d = 1'b1;
            state_d  = SPG_HANDOFF;
          end
        end
      end
      SPG_STAT: begin
        if (!txv_q || i_tx_ready) begin
          if (idx_q == 3'(STATUS_LEN - 1)) begin
            txv_d   = 1'b0;
            state_d = SPG_IDLE;
          end else begin
            idx_d = idx_q + 3'd1;
            txv_d = 1'b1;
            case (idx_q + 3'd1)
              3'd1:    tx_d = STATUS_COUNT;
              3'd2:    tx_d = status_byte;
              3'd6:    tx_d = 8'(8'h00 - status_byte - RESERVED_BYTE - RESERVED_BYTE - RESERVED_BYTE);
              default: tx_d = RESERVED_BYTE;
            endcase
          end
        end
      end
      SPG_ARG: begin
        if (i_password_error) begin
          state_d = SPG_HALT;
        end else if (i_rx_valid) begin
          chip_d = area_chip;
          sa_d   = area_start;
          ea_d   = area_end;
          if (area_no_cells) begin
            state_d = SPG_HALT;
          end else if (!area_chip && flags_q[1]) begin
            state_d = SPG_ERASE;
          end else begin
            erase_go_d = 1'b1;
            state_d    = SPG_ERASE;
          end
        end
      end
      SPG_ERASE: begin
        // A sector erase under protection never finishes: no start pulse is issued.
        if (i_erase_done && !(flags_q[1] && !chip_q)) begin
          clr_d   = chip_q;
          state_d = SPG_IDLE;
        end
      end
      SPG_HANDOFF: begin
        if (i_password_error) begin
          state_d = SPG_HALT;
        end else if (i_service_done) begin
          state_d = SPG_IDLE;
        end
      end
      SPG_HALT: begin
        txv_d   = 1'b0;
        state_d = SPG_HALT;
      end
      default: begin
        state_d = SPG_HALT;
      end
    endcase
    if (state_q == SPG_HANDOFF && i_password_error) begin
      txv_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_q     <= SPG_IDLE;
      cmd_q       <= 8'h00;
      flags_q     <= 2'b00;
      idx_q       <= 3'd0;
      tx_q        <= 8'h00;
      txv_q       <= 1'b0;
      echo_halt_q <= 1'b0;
      pass_q      <= 1'b0;
      chip_q      <= 1'b0;
      sa_q        <= 16'h0000;
      ea_q        <= 16'h0000;
      erase_go_q  <= 1'b0;
      svc_go_q    <= 1'b0;
      clr_q       <= 1'b0;
    end else begin
      state_q     <= state_d;
      cmd_q       <= cmd_d;
      flags_q     <= flags_d;
      idx_q       <= idx_d;
      tx_q        <= tx_d;
      txv_q       <= txv_d;
      echo_halt_q <= echo_halt_d;
      pass_q      <= pass_d;
      chip_q      <= chip_d;
      sa_q        <= sa_d;
      ea_q        <= ea_d;
      erase_go_q  <= erase_go_d;
      svc_go_q    <= svc_go_d;
      clr_q       <= clr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    port_en_d = port_en_q;
    if (i_port_en_wr && i_serial_mode) begin
      port_en_d = i_port_en_wdata;
    end
    port_d = i_serial_mode && !port_en_q ? '0 : pin_s_q;
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      port_en_q <= 1'b0;
      pin_m_q   <= '0;
      pin_s_q   <= '0;
      port_q    <= '0;
      uart_m_q  <= 2'b11;
      uart_s_q  <= 2'b11;
    end else begin
      port_en_q <= port_en_d;
      pin_m_q   <= i_port_pins;
      pin_s_q   <= pin_m_q;
      port_q    <= port_d;
      uart_m_q  <= {i_uart_port_pin_b, i_uart_port_pin_a};
      uart_s_q  <= uart_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign o_tx_data                = tx_q;
  assign o_tx_valid               = txv_q && (state_q != SPG_HALT);
  assign o_service_start          = svc_go_q;
  assign o_service_cmd            = cmd_q;
  assign o_service_needs_password = pass_q;
  assign o_erase_start            = erase_go_q;
  assign o_erase_chip             = chip_q;
  assign o_erase_start_addr       = sa_q;
  assign o_erase_end_addr         = ea_q;
  assign o_clear_protect          = clr_q;
  assign o_port_en_rdata          = i_serial_mode ? port_en_q : 1'b0;
  assign o_port_inputs            = port_q;
  assign o_uart_port_pin_a        = uart_s_q[0];
  assign o_uart_port_pin_b        = uart_s_q[1];
  assign o_halted                 = (state_q == SPG_HALT);

endmodule : spg_core
`default_nettype wire

/* design/spg_pkg.sv */
package spg_pkg;

  localparam logic [7:0] START_MARK      = 8'h3a;
  localparam logic [7:0] STATUS_COUNT    = 8'h04;
  localparam logic [7:0] RESERVED_BYTE   = 8'h00;
  localparam int         STATUS_LEN      = 7;
  localparam int         RPROT_BIT       = 1;
  localparam int         BLANK_BIT       = 0;
  localparam logic [3:0] LAST_FLASH_BLOCK_RST = 4'hf;
  localparam logic [3:0] FIRST_FLASH_BLOCK_RST = 4'hc;
  localparam logic [15:0] BLOCK_SIZE     = 16'h1000;
  localparam logic [15:0] BLOCK_TAIL     = 16'h0fff;

  localparam logic [7:0] CMD_FLASH_WRITE = 8'h30;
  localparam logic [7:0] CMD_RAM_LOADER  = 8'h60;
  localparam logic [7:0] CMD_SUM_OUT     = 8'h90;
  localparam logic [7:0] CMD_PRODUCT_ID  = 8'hc0;
  localparam logic [7:0] CMD_STATUS_OUT  = 8'hc3;
  localparam logic [7:0] CMD_ERASE       = 8'hf0;
  localparam logic [7:0] CMD_PROTECT_SET = 8'hfa;

  typedef enum logic [1:0] {
    SPG_DENY = 2'b00,
    SPG_FREE = 2'b01,
    SPG_PASS = 2'b10
  } spg_perm_type;

  typedef enum logic [6:0] {
    SPG_IDLE   = 7'b0000001,
    SPG_ECHO   = 7'b0000010,
    SPG_STAT   = 7'b0000100,
    SPG_ARG    = 7'b0001000,
    SPG_ERASE  = 7'b0010000,
    SPG_HANDOFF = 7'b0100000,
    SPG_HALT   = 7'b1000000
  } spg_state_type;

endpackage : spg_pkg

/* design/spg_perm.sv */
`timescale 1ns/100ps
`default_nettype none
module spg_perm (
  input  wire logic [7:0]           i_cmd,
  input  wire logic                 i_read_protect_flag,
  input  wire logic                 i_not_blank,
  output spg_pkg::spg_perm_type     o_perm,
  output logic                      o_known
);
  import spg_pkg::*;

  // Chip and sector erase are both under the erase command; the area byte decides later.
  always_comb begin
    o_perm  = SPG_DENY;
    o_known = 1'b1;
    case (i_cmd)
      CMD_SUM_OUT, CMD_PRODUCT_ID, CMD_STATUS_OUT: begin
        o_perm = SPG_FREE;
      end
      CMD_FLASH_WRITE, CMD_RAM_LOADER: begin
        if (i_read_protect_flag) begin
          o_perm = SPG_DENY;
        end else if (i_not_blank) begin
          o_perm = SPG_PASS;
        end else begin
          o_perm = SPG_FREE;
        end
      end
      CMD_ERASE: begin
        o_perm = (i_not_blank) ? SPG_PASS : SPG_FREE;
      end
      CMD_PROTECT_SET: begin
        o_perm = (i_not_blank) ? SPG_PASS : SPG_DENY;
      end
      default: begin
        o_known = 1'b0;
      end
    endcase
  end

endmodule : spg_perm
`default_nettype wire

/* design/spg_area.sv */
`timescale 1ns/100ps
`default_nettype none
module spg_area (
  input  wire logic [7:0]  i_area,
  input  wire logic [3:0]  i_first_flash_block,
  input  wire logic [3:0]  i_last_flash_block,
  output logic             o_chip,
  output logic [15:0]      o_start_addr,
  output logic [15:0]      o_end_addr,
  output logic             o_no_cells
);
  import spg_pkg::*;

  logic [3:0] erase_first_block;
  logic [3:0] erase_last_block;

  always_comb begin
    erase_first_block = i_area[7:4];
    erase_last_block  = i_area[3:0];
    o_chip       = erase_first_block > erase_last_block;
    o_start_addr = 16'({erase_first_block, 12'h000});
    o_end_addr   = 16'({erase_last_block, 12'h000}) | BLOCK_TAIL;
    o_no_cells   = !o_chip && ((erase_first_block < i_first_flash_block) ||
                               (erase_last_block > i_last_flash_block));
  end

endmodule : spg_area
`default_nettype wire

/* verification/spg_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module spg_sva #(
  parameter int PORT_BITS = 24
) (
  input wire logic                 i_clk,
  input wire logic                 i_nrst,
  input wire logic                 i_serial_mode,
  input wire logic [7:0]           i_rx_data,
  input wire logic                 i_tx_ready,
  input wire logic                 i_erase_done,
  input wire logic                 o_tx_valid,
  input wire logic [7:0]           o_tx_data,
  input wire logic                 o_erase_start,
  input wire logic                 o_erase_chip,
  input wire logic [15:0]          o_erase_start_addr,
  input wire logic [15:0]          o_erase_end_addr,
  input wire logic                 o_clear_protect,
  input wire logic                 o_port_en_rdata,
  input wire logic [PORT_BITS-1:0] o_port_inputs,
  input wire logic                 o_halted
);
  logic [2:0] frc_q;
  logic [2:0] frc_d;

  // Counts settled cycles of forced port inputs, saturating.
  always_comb begin
    frc_d = 3'h0;
    if (i_serial_mode && !o_port_en_rdata) begin
      frc_d = (frc_q == 3'h7) ? frc_q : frc_q + 3'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    frc_q <= i_nrst ? frc_d : 3'h0;
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_halt_no_tx: assert property (o_halted |-> !o_tx_valid)
    else $error("tx valid while halted");
  a_halt_stays: assert property (o_halted |=> o_halted)
    else $error("halt left without reset");
  a_tx_holds: assert property (o_tx_valid && !i_tx_ready |=> o_halted || (o_tx_valid && $stable(o_tx_data)))
    else $error("tx byte dropped before taken");
  a_sector_addr: assert property (o_erase_start && !o_erase_chip |->
    o_erase_start_addr == {$past(i_rx_data[7:4]), 12'h000} && o_erase_end_addr == {$past(i_rx_data[3:0]), 12'hfff})
    else $error("sector addresses wrong");
  a_chip_decode: assert property (o_erase_start |-> o_erase_chip == ($past(i_rx_data[7:4]) > $past(i_rx_data[3:0])))
    else $error("chip or sector choice wrong");
  a_clear_cause: assert property (o_clear_protect |-> $past(i_erase_done) && $past(o_erase_chip))
    else $error("protection cleared without chip erase");
  a_start_pulse: assert property (o_erase_start |=> !o_erase_start)
    else $error("erase start longer than one cycle");
  a_port_forced: assert property (frc_q >= 3'h5 |-> o_port_inputs == '0)
    else $error("port inputs not forced");
  a_port_mode: assert property (!i_serial_mode && !$past(i_serial_mode) |-> !o_port_en_rdata)
    else $error("port enable visible outside serial mode");

  c_status: cover property (o_tx_valid && i_tx_ready && o_tx_data == 8'h3a);
  c_chip: cover property (o_erase_start && o_erase_chip);
  c_halt: cover property ($rose(o_halted));
endmodule : spg_sva

bind spg_core spg_sva #(.PORT_BITS(PORT_BITS)) u_sva (.i_clk(i_clk), .i_nrst(i_nrst), .i_serial_mode(i_serial_mode),
  .i_rx_data(i_rx_data), .i_tx_ready(i_tx_ready), .i_erase_done(i_erase_done), .o_tx_valid(o_tx_valid),
  .o_tx_data(o_tx_data), .o_erase_start(o_erase_start), .o_erase_chip(o_erase_chip),
  .o_erase_start_addr(o_erase_start_addr), .o_erase_end_addr(o_erase_end_addr), .o_clear_protect(o_clear_protect),
  .o_port_en_rdata(o_port_en_rdata), .o_port_inputs(o_port_inputs), .o_halted(o_halted));
`default_nettype wire

/* verification/spg_ctrl_model.sv */
`timescale 1ns/100ps
`default_nettype none
module spg_ctrl_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_tx_valid,
  output logic [7:0]      o_rx_data,
  output logic            o_rx_valid,
  output logic            o_tx_ready
);
  logic [7:0] got[$];
  logic       slow = 1'b0;
  logic [1:0] ph = 2'h0;

  initial begin
    o_rx_data = 8'h00;
    o_rx_valid = 1'b0;
    o_tx_ready = 1'b1;
  end

  // Collects every byte taken; slow mode accepts one cycle in four.
  always @(posedge i_clk) begin
    ph <= ph + 2'h1;
    o_tx_ready <= !slow || (ph == 2'h3);
    if (i_tx_valid && o_tx_ready) got.push_back(i_tx_data);
  end

  // Sends one byte; the line shows the inverse afterwards. No sector erase under protection is sent.
  task automatic send(input logic [7:0] b);
    @(posedge i_clk);
    o_rx_data  <= b;
    o_rx_valid <= 1'b1;
    @(posedge i_clk);
    o_rx_valid <= 1'b0;
    o_rx_data  <= ~b;
  endtask : send
endmodule : spg_ctrl_model
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        ser = 1'b1;
  logic        prot = 1'b0;
  logic        nb = 1'b0;
  logic        pwe = 1'b0;
  logic        edone = 1'b0;
  logic        pwr = 1'b0;
  logic        pwd = 1'b0;
  logic        ua = 1'b1;
  logic        sdone = 1'b0;
  logic [3:0]  fb = 4'hc;
  logic [3:0]  lb = 4'hf;
  logic        svs;
  logic [7:0]  svc;
  logic        svp;
  logic        ub_o;
  logic [23:0] pins = 24'h5a5a5a;
  logic [7:0]  rxd;
  logic        rxv;
  logic        rdy;
  logic [7:0]  txd;
  logic        txv;
  logic        est;
  logic        chip;
  logic [15:0] sa;
  logic [15:0] ea;
  logic        clr;
  logic        ren;
  logic [23:0] pin_o;
  logic        ua_o;
  logic        halted;
  int          err_count = 0;
  int          compares = 0;

  always #20 clk = ~clk;

  spg_core u_dut (.i_clk(clk), .i_nrst(nrst), .i_serial_mode(ser), .i_rx_data(rxd), .i_rx_valid(rxv),
    .o_tx_data(txd), .o_tx_valid(txv), .i_tx_ready(rdy), .i_read_protect_flag(prot), .i_top_not_blank(nb),
    .i_password_error(pwe), .i_service_done(sdone), .o_service_start(svs), .o_service_cmd(svc),
    .o_service_needs_password(svp), .o_erase_start(est), .o_erase_chip(chip), .o_erase_start_addr(sa),
    .o_erase_end_addr(ea), .i_erase_done(edone), .o_clear_protect(clr), .i_first_flash_block(fb),
    .i_last_flash_block(lb), .i_port_en_wr(pwr), .i_port_en_wdata(pwd), .o_port_en_rdata(ren),
    .i_port_pins(pins), .o_port_inputs(pin_o), .i_uart_port_pin_a(ua), .i_uart_port_pin_b(~ua),
    .o_uart_port_pin_a(ua_o), .o_uart_port_pin_b(ub_o), .o_halted(halted));

  spg_ctrl_model u_m (.i_clk(clk), .i_tx_data(txd), .i_tx_valid(txv), .o_rx_data(rxd), .o_rx_valid(rxv),
    .o_tx_ready(rdy));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rst();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    u_m.got.delete();
  endtask : rst

  task automatic wt(input int n);
    repeat (400) if (u_m.got.size() < n) @(negedge clk);
    chk(u_m.got.size(), n);
  endtask : wt

  task automatic t_status(input logic p, input logic n);
    logic [7:0] s;
    logic [7:0] e[8];
    s = {6'h00, p, n};
    e = '{8'hc3, 8'h3a, 8'h04, s, 8'h00, 8'h00, 8'h00, 8'h00 - s};
    @(posedge clk);
    prot <= p;
    nb <= n;
    u_m.send(8'hc3);
    wt(8);
    for (int i = 0; i < 8; i++) chk(u_m.got[i], e[i]);
    u_m.got.delete();
    repeat (4) @(negedge clk);
  endtask : t_status

  task automatic t_deny(input logic [7:0] c, input logic p, input logic n, input logic pw);
    @(posedge clk);
    prot <= p;
    nb <= n;
    u_m.send(c);
    wt(1);
    chk(u_m.got[0], c);
    if (pw) begin
      @(posedge clk);
      pwe <= 1'b1;
      @(posedge clk);
      pwe <= 1'b0;
    end
    repeat (3) @(negedge clk);
    chk(halted, 1'b1);
    u_m.send(8'hc3);
    repeat (20) @(negedge clk);
    chk(u_m.got.size(), 1);
    rst();
  endtask : t_deny

  task automatic t_erase(input logic [7:0] a, input logic p);
    logic c;
    c = a[7:4] > a[3:0];
    @(posedge clk);
    prot <= p;
    nb <= 1'b0;
    u_m.send(8'hf0);
    wt(1);
    u_m.send(a);
    repeat (400) if (!est && !halted) @(negedge clk);
    chk(halted, !c && ((a[7:4] < fb) || (a[3:0] > lb)));
    if (!halted) begin
      chk({est, chip}, {1'b1, c});
      if (!c) chk({sa, ea}, {a[7:4], 12'h000, a[3:0], 12'hfff});
      @(posedge clk);
      edone <= 1'b1;
      @(posedge clk);
      edone <= 1'b0;
      @(negedge clk);
      chk(clr, c);
    end
    rst();
  endtask : t_erase

  // A handed-off command waits for the handler, then the next command is served.
  task automatic t_service(input logic [7:0] c, input logic p, input logic n, input logic pw);
    @(posedge clk);
    prot <= p;
    nb <= n;
    u_m.send(c);
    wt(1);
    repeat (20) if (!svs) @(negedge clk);
    chk({svs, svc, svp}, {1'b1, c, pw});
    @(posedge clk);
    sdone <= 1'b1;
    @(posedge clk);
    sdone <= 1'b0;
    u_m.send(8'hc3);
    wt(9);
    chk(u_m.got[1], 8'hc3);
    chk(u_m.got[4], {6'h00, p, n});
    rst();
  endtask : t_service

  task automatic t_ports();
    @(posedge clk);
    ser <= 1'b0;
    pwr <= 1'b1;
    pwd <= 1'b1;
    @(posedge clk);
    pwr <= 1'b0;
    ser <= 1'b1;
    ua <= 1'b0;
    repeat (6) @(negedge clk);
    chk({ren, pin_o, ua_o, ub_o}, {1'b0, 24'h000000, 1'b0, 1'b1});
    @(posedge clk);
    pwr <= 1'b1;
    @(posedge clk);
    pwr <= 1'b0;
    repeat (5) @(negedge clk);
    chk({ren, pin_o}, {1'b1, pins});
    @(posedge clk);
    ser <= 1'b0;
    repeat (3) @(negedge clk);
    chk(ren, 1'b0);
  endtask : t_ports

  task automatic test_done();
    if (err_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      u_m.slow = (i == 2);
      t_status(i[1], i[0]);
    end
    u_m.slow = 1'b0;
    t_deny(8'h30, 1'b1, 1'b0, 1'b0);
    t_deny(8'h60, 1'b1, 1'b1, 1'b0);
    t_deny(8'hfa, 1'b0, 1'b0, 1'b0);
    t_deny(8'h55, 1'b0, 1'b0, 1'b0);
    t_deny(8'hf0, 1'b0, 1'b1, 1'b1);
    t_erase(8'hcf, 1'b0);
    t_erase(8'hdd, 1'b0);
    t_erase(8'hfc, 1'b1);
    t_erase(8'h10, 1'b0);
    t_erase(8'h12, 1'b0);
    lb <= 4'hd;
    t_erase(8'hce, 1'b0);
    lb <= 4'hf;
    t_service(8'h90, 1'b1, 1'b1, 1'b0);
    t_service(8'h30, 1'b0, 1'b1, 1'b1);
    t_service(8'hfa, 1'b1, 1'b1, 1'b1);
    t_ports();
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    test_done();
  end
endmodule : tb_top
`default_nettype wire
